// *** dv/scg_clock_gen_properties.sv ***
// Port-level concurrent checks for the system clock generator
`timescale 1ns/10ps
`default_nettype none
module scg_clock_gen_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rd_data,
    input wire logic main_osc_en,
    input wire logic sub_osc_en,
    input wire logic stop_instruction,
    input wire logic wait_instruction,
    input wire logic ext_wake,
    input wire logic irq_accept,
    input wire logic core_clk,
    input wire logic core_halted
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    logic in_wait;
    logic wait_go;
    // Wait and stabilising look the same at the ports, so wait is tracked
    assign wait_go = wait_instruction && !stop_instruction && !core_halted;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_wait <= 1'b0;
        end else if (wait_go) begin
            in_wait <= 1'b1;
        end else if (irq_accept) begin
            in_wait <= 1'b0;
        end
    end
    AST_POWER_ON: assert property (
        $past(rst) |-> main_osc_en && !sub_osc_en && !core_halted)
        else $error("Wrong oscillator or halt state after reset");
    AST_READ_IDLE: assert property (
        !$past(rd_en) |-> rd_data == 8'h00)
        else $error("Read data not zero outside the read slot");
    AST_MAIN_STOP: assert property (
        wr_en && addr == scg_pkg::ADDR_CPU_MODE && wr_data[5] && !core_halted
        |-> ##[1:2] !main_osc_en)
        else $error("Main stop bit did not stop main oscillator");
    AST_STOP_ENTRY: assert property (
        stop_instruction && !core_halted |=> core_halted)
        else $error("Stop did not halt the core clock");
    AST_STOP_OSC_OFF: assert property (
        stop_instruction && !core_halted
        |-> ##[1:40] (!main_osc_en && !sub_osc_en))
        else $error("Oscillators still running in stop");
    AST_HALT_HIGH: assert property (
        core_halted && $past(core_halted) && $past(core_clk) |-> core_clk)
        else $error("Core clock left high level while halted");
    AST_WAKE_RESTART: assert property (
        ext_wake && core_halted && !main_osc_en && !sub_osc_en
        |=> main_osc_en || sub_osc_en)
        else $error("Wake did not restart an oscillator");
    AST_RELEASE_OSC: assert property (
        $fell(core_halted) |-> main_osc_en || sub_osc_en)
        else $error("Core clock released with no oscillator");
    AST_WAIT_ENTRY: assert property (
        wait_go |=> core_halted)
        else $error("Wait did not halt the core clock");
    AST_WAIT_RELEASE: assert property (
        in_wait && irq_accept |=> !core_halted)
        else $error("Accepted interrupt did not end wait");
    AST_PHASE_MIN: assert property (
        $changed(core_clk) |=> $stable(core_clk))
        else $error("Core clock phase of a single cycle");
    cover property ($fell(core_halted) && !in_wait);
    cover property (in_wait && irq_accept);
    cover property ($rose(core_clk));
endmodule
bind scg_clock_gen scg_clock_gen_properties scg_clock_gen_properties_inst (
    .sys_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .main_osc_en, .sub_osc_en, .stop_instruction, .wait_instruction,
    .ext_wake, .irq_accept, .core_clk, .core_halted
);
`default_nettype wire

// *** dv/scg_osc_model.sv ***
// Behavioural main and sub resonators, sub pins doubling as port lines
`timescale 1ns/10ps
`default_nettype none
module scg_osc_model #(
    parameter int MAIN_HALF = 2,
    parameter int SUB_HALF = 12
) (
    input wire logic sys_clk,
    input wire logic main_osc_en,
    input wire logic sub_osc_en,
    input wire logic sub_osc_in_o,
    input wire logic sub_osc_in_oe,
    input wire logic sub_osc_out,
    input wire logic sub_osc_out_oe,
    output logic main_osc_in,
    output logic sub_osc_in,
    output logic sub_osc_out_i
);
    int main_cnt = 0;
    int sub_cnt = 0;
    logic main_lvl = 1'b0;
    logic sub_lvl = 1'b0;
    logic float_lvl = 1'b0;
    // Resonators start at once; a stopped one settles low
    always @(posedge sys_clk) begin
        float_lvl <= ~float_lvl;
        main_cnt <= (main_cnt + 1) % MAIN_HALF;
        sub_cnt <= (sub_cnt + 1) % SUB_HALF;
        if (main_cnt == 0) begin
            main_lvl <= main_osc_en & ~main_lvl;
        end
        if (sub_cnt == 0) begin
            sub_lvl <= sub_osc_en & ~sub_lvl;
        end
    end
    // Undriven port pins have no pull, so they wander every cycle
    assign main_osc_in = main_lvl;
    assign sub_osc_in = sub_osc_en ? sub_lvl :
        (sub_osc_in_oe ? sub_osc_in_o : float_lvl);
    assign sub_osc_out_i = sub_osc_out_oe ? sub_osc_out : float_lvl;
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking testbench for the system clock generator
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int MH = 2;
    localparam int SH = 12;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic stop_instruction = 1'b0;
    logic wait_instruction = 1'b0;
    logic ext_wake = 1'b0;
    logic irq_accept = 1'b0;
    logic scl_in = 1'b1;
    logic sda_in = 1'b1;
    logic [7:0] rd_data;
    logic main_osc_in, main_osc_out, main_osc_en, sub_osc_in;
    logic sub_osc_in_o, sub_osc_in_oe, sub_osc_out_i, sub_osc_out;
    logic sub_osc_out_oe, sub_osc_en, core_clk, core_halted;
    int n_tests = 0;
    int miscompares = 0;
    int cycles = 0;
    scg_clock_gen scg_clock_gen_inst (
        .sys_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
        .main_osc_in, .main_osc_out, .main_osc_en, .sub_osc_in,
        .sub_osc_in_o, .sub_osc_in_oe, .sub_osc_out_i, .sub_osc_out,
        .sub_osc_out_oe, .sub_osc_en, .stop_instruction, .wait_instruction,
        .ext_wake, .irq_accept, .scl_in, .sda_in, .core_clk, .core_halted
    );
    scg_osc_model #(.MAIN_HALF(MH), .SUB_HALF(SH)) scg_osc_model_inst (
        .sys_clk, .main_osc_en, .sub_osc_en, .sub_osc_in_o, .sub_osc_in_oe,
        .sub_osc_out, .sub_osc_out_oe, .main_osc_in, .sub_osc_in,
        .sub_osc_out_i
    );
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // The whole run needs a few thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask
    // Skips the rise that applies a new divider, then times one period
    task automatic period(input logic [7:0] exp);
        time t0;
        repeat (2) @(posedge core_clk);
        t0 = $time;
        @(posedge core_clk);
        chk(8'(($time - t0) / 40), exp);
    endtask
    task automatic test_reset;
        cyc(1);
        chk({main_osc_en, sub_osc_en, sub_osc_in_oe}, 8'h04);
        chk(core_halted, 1'b0);
        wr(scg_pkg::ADDR_SUB_PORT, 8'h0f);
        chk({sub_osc_in_o, sub_osc_in_oe, sub_osc_out, sub_osc_out_oe},
            8'h0f);
        rchk(scg_pkg::ADDR_SUB_PORT, 8'h3f);
        rchk(scg_pkg::ADDR_CPU_MODE, 8'h40);
        rchk(scg_pkg::ADDR_MISC_CLOCK_SETTINGS, 8'h00);
        rchk(scg_pkg::ADDR_STAB_PRESCALER, 8'hff);
        rchk(scg_pkg::ADDR_STAB_TIMER, 8'h01);
        rchk(8'h00, 8'h00);
        period(8'(16 * MH));
    endtask
    task automatic test_speeds;
        logic [7:0] code [3] = '{8'h00, 8'h50, 8'h90};
        logic [7:0] len [3];
        len = '{8'(4 * MH), 8'(16 * MH), 8'(4 * SH)};
        // Sub is enabled one step before low speed so it has settled
        for (int i = 0; i < 3; i++) begin
            wr(scg_pkg::ADDR_CPU_MODE, code[i]);
            period(len[i]);
        end
    endtask
    task automatic test_main_stop;
        wr(scg_pkg::ADDR_CPU_MODE, 8'hb0);
        cyc(1);
        chk({main_osc_en, main_osc_out}, 8'h00);
        period(8'(4 * SH));
        wr(scg_pkg::ADDR_CPU_MODE, 8'h90);
        cyc(1);
        chk(main_osc_en, 1'b1);
        wr(scg_pkg::ADDR_CPU_MODE, 8'h50);
        period(8'(16 * MH));
    endtask
    task automatic test_wait;
        @(posedge sys_clk);
        wait_instruction <= 1'b1;
        @(posedge sys_clk);
        wait_instruction <= 1'b0;
        cyc(60);
        chk({core_halted, core_clk, main_osc_en, sub_osc_en}, 8'h0f);
        @(posedge sys_clk);
        irq_accept <= 1'b1;
        @(posedge sys_clk);
        irq_accept <= 1'b0;
        #1;
        chk(core_halted, 1'b0);
        period(8'(16 * MH));
    endtask
    task automatic test_stop(input logic sel);
        int i;
        i = 0;
        wr(scg_pkg::ADDR_MISC_CLOCK_SETTINGS, {7'h00, sel});
        wr(scg_pkg::ADDR_STAB_PRESCALER, 8'h03);
        wr(scg_pkg::ADDR_STAB_TIMER, 8'h00);
        @(posedge sys_clk);
        stop_instruction <= 1'b1;
        @(posedge sys_clk);
        stop_instruction <= 1'b0;
        cyc(40);
        chk({core_clk, main_osc_en, sub_osc_en}, 8'h04);
        chk({main_osc_out, sub_osc_out}, 8'h00);
        rchk(scg_pkg::ADDR_STATUS, 8'h05);
        rchk(scg_pkg::ADDR_STAB_PRESCALER, sel ? 8'h03 : 8'hff);
        rchk(scg_pkg::ADDR_STAB_TIMER, {7'h00, ~sel});
        // Shorten the settling count for the run
        wr(scg_pkg::ADDR_STAB_PRESCALER, 8'h03);
        wr(scg_pkg::ADDR_STAB_TIMER, 8'h00);
        @(posedge sys_clk);
        ext_wake <= 1'b1;
        @(posedge sys_clk);
        ext_wake <= 1'b0;
        cyc(1);
        chk({main_osc_en, sub_osc_en, core_halted, core_clk}, 8'h0f);
        rchk(scg_pkg::ADDR_STATUS, 8'h0d);
        while (core_halted === 1'b1 && i < 1000) begin
            cyc(1);
            i++;
        end
        chk(8'(i >= 120 * MH && i <= 136 * MH), 8'h01);
    endtask
    task automatic test_auto(input logic ws);
        wr(scg_pkg::ADDR_MISC_CLOCK_SETTINGS, {5'h00, ws, 2'h2});
        // Main may stop only once low speed runs from the sub clock
        wr(scg_pkg::ADDR_CPU_MODE, 8'h90);
        repeat (2) @(posedge core_clk);
        wr(scg_pkg::ADDR_CPU_MODE, 8'hb0);
        repeat (3) @(posedge core_clk);
        @(posedge sys_clk);
        if (ws) begin
            sda_in <= ~sda_in;
        end else begin
            scl_in <= ~scl_in;
        end
        cyc(3);
        chk(main_osc_en, 1'b1);
        repeat (ws ? 6 : 4) @(posedge core_clk);
        rchk(scg_pkg::ADDR_CPU_MODE, 8'h90);
        @(posedge core_clk);
        rchk(scg_pkg::ADDR_CPU_MODE, 8'h50);
        period(8'(16 * MH));
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        test_speeds();
        test_main_stop();
        test_wait();
        test_stop(1'b0);
        test_stop(1'b1);
        test_auto(1'b0);
        test_auto(1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire

// *** hw/scg_clock_gen.sv ***
// System clock generator: speed modes, stop, wait and automatic switch
//
// Behaviour
// - At power-on only main oscillator runs
// - Middle speed divides main by 8, reset default
// - High speed divides main by two
// - Low speed divides sub oscillator by two
// - Main clock stop bit stops main oscillator
// - Stop holds core clock high, oscillators off
// - Stop with select 0 loads FF and 01
// - Select 1 keeps software-loaded prescaler and timer
// - Prescaler counts chosen oscillator divided by 16
// - Wake restarts oscillator, clock held high meanwhile
// - Core clock returns on timer underflow
// - No stabilisation wait after reset
// - Wait holds clock high, resumes on interrupt
// - Bus edge in low speed starts middle
// - Automatic switch waits five or seven cycles
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none

module scg_clock_gen (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    input wire logic main_osc_in,
    output logic main_osc_out,
    output logic main_osc_en,
    input wire logic sub_osc_in,
    output logic sub_osc_in_o,
    output logic sub_osc_in_oe,
    input wire logic sub_osc_out_i,
    output logic sub_osc_out,
    output logic sub_osc_out_oe,
    output logic sub_osc_en,
    input wire logic stop_instruction,
    input wire logic wait_instruction,
    input wire logic ext_wake,
    input wire logic irq_accept,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic core_clk,
    output logic core_halted
);

    typedef struct packed {
        scg_pkg::scg_state_type st;
        scg_pkg::scg_mode_type act_mode;
        logic [1:0] cpu_speed;
        logic main_stop;
        logic sub_en;
        logic stab_sel;
        logic auto_en;
        logic auto_wait_sel;
        logic [7:0] pre_latch;
        logic [7:0] pre;
        logic [7:0] tmr_latch;
        logic [7:0] tmr;
        logic [3:0] div16;
        logic [1:0] div_cnt;
        logic core_clk;
        logic main_q;
        logic sub_q;
        logic scl_q;
        logic sda_q;
        logic auto_busy;
        logic [2:0] auto_cnt;
        logic [1:0] port_data;
        logic [1:0] port_dir;
        logic [7:0] rd_data;
        logic main_en;
        logic sub_run;
        logic main_out;
        logic sub_out;
        logic sub_out_oe;
        logic sub_in_o;
        logic sub_in_oe;
        logic halted;
    } scg_regs_type;

    // Only the main oscillator runs out of reset; no settling wait here
    localparam scg_regs_type RESET_STATE = '{
        st: scg_pkg::ST_RUN,
        act_mode: scg_pkg::MODE_MIDDLE,
        cpu_speed: scg_pkg::RESET_SPEED,
        pre_latch: scg_pkg::PRE_STOP_LOAD,
        pre: scg_pkg::PRE_STOP_LOAD,
        tmr_latch: scg_pkg::TMR_STOP_LOAD,
        tmr: scg_pkg::TMR_STOP_LOAD,
        core_clk: 1'b1,
        main_en: 1'b1,
        // Bus lines idle high; a low reset value would fake an edge
        scl_q: 1'b1,
        sda_q: 1'b1,
        default: '0
    };

    scg_regs_type s;
    scg_regs_type next_s;
    logic main_rise;
    logic sub_rise;
    logic core_tick;
    logic stab_tick;
    logic bus_edge;
    logic osc_gated;
    logic [1:0] half_last;
    logic [2:0] auto_last;

    // Reserved speed code falls back to middle speed
    function automatic scg_pkg::scg_mode_type speed_to_mode(
        input logic [1:0] speed
    );
        case (speed)
            scg_pkg::SPEED_HIGH: speed_to_mode = scg_pkg::MODE_HIGH;
            scg_pkg::SPEED_LOW: speed_to_mode = scg_pkg::MODE_LOW;
            default: speed_to_mode = scg_pkg::MODE_MIDDLE;
        endcase
    endfunction

    always_comb begin
        next_s = s;
        next_s.main_q = main_osc_in;
        next_s.sub_q = sub_osc_in;
        next_s.scl_q = scl_in;
        next_s.sda_q = sda_in;
        main_rise = main_osc_in & ~s.main_q;
        sub_rise = sub_osc_in & ~s.sub_q;
        bus_edge = (scl_in ^ s.scl_q) | (sda_in ^ s.sda_q);
        half_last = (s.act_mode == scg_pkg::MODE_MIDDLE) ?
            scg_pkg::HALF_LAST_MIDDLE : scg_pkg::HALF_LAST_OTHER;
        auto_last = s.auto_wait_sel ?
            scg_pkg::AUTO_LAST_LONG : scg_pkg::AUTO_LAST_SHORT;
        core_tick = (s.act_mode == scg_pkg::MODE_LOW) ? sub_rise : main_rise;
        // Stabilising count follows the sub oscillator when the main stop bit is set, else the main
        stab_tick = s.main_stop ? sub_rise : main_rise;

        // Register writes; hardware updates below take priority
        if (wr_en) begin
            case (addr)
                scg_pkg::ADDR_CPU_MODE: begin
                    next_s.cpu_speed =
                        wr_data[scg_pkg::CPUM_SPEED_LSB +: 2];
                    next_s.main_stop = wr_data[scg_pkg::CPUM_MAIN_STOP];
                    next_s.sub_en = wr_data[scg_pkg::CPUM_SUB_EN];
                end
                scg_pkg::ADDR_MISC_CLOCK_SETTINGS: begin
                    next_s.stab_sel = wr_data[scg_pkg::MISC_STAB_SEL];
                    next_s.auto_en = wr_data[scg_pkg::MISC_AUTO_EN];
                    next_s.auto_wait_sel = wr_data[scg_pkg::MISC_AUTO_WAIT];
                end
                scg_pkg::ADDR_STAB_PRESCALER: begin
                    next_s.pre_latch = wr_data;
                    next_s.pre = wr_data;
                end
                scg_pkg::ADDR_STAB_TIMER: begin
                    next_s.tmr_latch = wr_data;
                    next_s.tmr = wr_data;
                end
                scg_pkg::ADDR_SUB_PORT: begin
                    next_s.port_data = wr_data[scg_pkg::PORT_DATA_LSB +: 2];
                    next_s.port_dir = wr_data[scg_pkg::PORT_DIR_LSB +: 2];
                end
                default: begin
                end
            endcase
        end

        // Read data stands only in the cycle after the strobe
        next_s.rd_data = '0;
        if (rd_en) begin
            case (addr)
                scg_pkg::ADDR_CPU_MODE: begin
                    next_s.rd_data[scg_pkg::CPUM_SPEED_LSB +: 2] = s.cpu_speed;
                    next_s.rd_data[scg_pkg::CPUM_MAIN_STOP] = s.main_stop;
                    next_s.rd_data[scg_pkg::CPUM_SUB_EN] = s.sub_en;
                end
                scg_pkg::ADDR_MISC_CLOCK_SETTINGS: begin
                    next_s.rd_data[scg_pkg::MISC_STAB_SEL] = s.stab_sel;
                    next_s.rd_data[scg_pkg::MISC_AUTO_EN] = s.auto_en;
                    next_s.rd_data[scg_pkg::MISC_AUTO_WAIT] = s.auto_wait_sel;
                end
                scg_pkg::ADDR_STAB_PRESCALER: next_s.rd_data = s.pre;
                scg_pkg::ADDR_STAB_TIMER: next_s.rd_data = s.tmr;
                scg_pkg::ADDR_STATUS: begin
                    next_s.rd_data[1:0] = s.act_mode;
                    next_s.rd_data[scg_pkg::STAT_HALTED] = s.halted;
                    next_s.rd_data[scg_pkg::STAT_STABILISING] =
                        (s.st == scg_pkg::ST_STAB);
                end
                scg_pkg::ADDR_SUB_PORT: begin
                    next_s.rd_data[scg_pkg::PORT_DATA_LSB +: 2] = s.port_data;
                    next_s.rd_data[scg_pkg::PORT_DIR_LSB +: 2] = s.port_dir;
                    next_s.rd_data[scg_pkg::PORT_PIN_LSB +: 2] =
                        {sub_osc_out_i, sub_osc_in};
                end
                default: next_s.rd_data = '0;
            endcase
        end

        // Stop and wait sequencing
        case (s.st)
            scg_pkg::ST_RUN: begin
                if (stop_instruction) begin
                    next_s.st = scg_pkg::ST_STOP;
                    next_s.div16 = '0;
                    if (!s.stab_sel) begin
                        next_s.pre = scg_pkg::PRE_STOP_LOAD;
                        next_s.tmr = scg_pkg::TMR_STOP_LOAD;
                    end
                end else if (wait_instruction) begin
                    next_s.st = scg_pkg::ST_WAIT;
                end
            end
            scg_pkg::ST_WAIT: begin
                // Oscillators never stopped, so no settling is needed
                if (irq_accept) begin
                    next_s.st = scg_pkg::ST_RUN;
                end
            end
            scg_pkg::ST_STOP: begin
                if (ext_wake) begin
                    next_s.st = scg_pkg::ST_STAB;
                end
            end
            scg_pkg::ST_STAB: begin
                if (stab_tick) begin
                    next_s.div16 = s.div16 + 4'h1;
                    if (s.div16 == scg_pkg::STAB_DIV_LAST) begin
                        if (s.pre == 8'h00) begin
                            next_s.pre = s.pre_latch;
                            if (s.tmr == 8'h00) begin
                                next_s.tmr = s.tmr_latch;
                                next_s.st = scg_pkg::ST_RUN;
                            end else begin
                                next_s.tmr = s.tmr - 8'h01;
                            end
                        end else begin
                            next_s.pre = s.pre - 8'h01;
                        end
                    end
                end
            end
            default: next_s.st = scg_pkg::ST_RUN;
        endcase

        // A bus edge in low speed starts the main oscillator
        if (s.act_mode != scg_pkg::MODE_LOW) begin
            next_s.auto_busy = 1'b0;
        end else if (s.st == scg_pkg::ST_RUN && s.auto_en && !s.auto_busy
                     && bus_edge) begin
            next_s.auto_busy = 1'b1;
            next_s.auto_cnt = '0;
            next_s.main_stop = 1'b0;
        end

        // Core clock divider; when halted it may only rise, then freezes
        if (core_tick && (s.st == scg_pkg::ST_RUN || !s.core_clk)) begin
            if (s.div_cnt == half_last) begin
                next_s.div_cnt = '0;
                next_s.core_clk = ~s.core_clk;
                if (!s.core_clk) begin
                    // Bus edge is random within a cycle, hence the spread
                    if (s.auto_busy) begin
                        if (s.auto_cnt == auto_last) begin
                            next_s.auto_busy = 1'b0;
                            next_s.cpu_speed = scg_pkg::SPEED_MIDDLE;
                        end else begin
                            next_s.auto_cnt = s.auto_cnt + 3'h1;
                        end
                    end
                    // Source changes only at a rising edge so the low
                    // phase is whole and the next high phase is new
                    next_s.act_mode = speed_to_mode(next_s.cpu_speed);
                end
            end else begin
                next_s.div_cnt = s.div_cnt + 2'h1;
            end
        end

        // Oscillators stop only once the core clock is parked high
        osc_gated = (next_s.st == scg_pkg::ST_STOP) && next_s.core_clk;
        next_s.main_en = !next_s.main_stop && !osc_gated;
        next_s.sub_run = next_s.sub_en && !osc_gated;
        next_s.main_out = next_s.main_en & ~main_osc_in;
        // Sub pins serve as port pins until the oscillator is enabled
        next_s.sub_out_oe = next_s.sub_en | next_s.port_dir[1];
        next_s.sub_out = next_s.sub_en ? (next_s.sub_run & ~sub_osc_in)
                                       : next_s.port_data[1];
        next_s.sub_in_oe = !next_s.sub_en & next_s.port_dir[0];
        next_s.sub_in_o = next_s.port_data[0];
        next_s.halted = (next_s.st != scg_pkg::ST_RUN);
    end

    // Reset restarts straight into middle speed with no settling count
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd_data;
    assign main_osc_out = s.main_out;
    assign main_osc_en = s.main_en;
    assign sub_osc_in_o = s.sub_in_o;
    assign sub_osc_in_oe = s.sub_in_oe;
    assign sub_osc_out = s.sub_out;
    assign sub_osc_out_oe = s.sub_out_oe;
    assign sub_osc_en = s.sub_run;
    assign core_clk = s.core_clk;
    assign core_halted = s.halted;

endmodule

`default_nettype wire

// *** hw/scg_pkg.sv ***
// Constants and types shared by the system clock generator
package scg_pkg;

    // Register offsets on the 8-bit register port
    localparam logic [7:0] ADDR_STAB_PRESCALER = 8'h20;
    localparam logic [7:0] ADDR_STAB_TIMER = 8'h21;
    localparam logic [7:0] ADDR_STATUS = 8'h30;
    localparam logic [7:0] ADDR_SUB_PORT = 8'h31;
    localparam logic [7:0] ADDR_MISC_CLOCK_SETTINGS = 8'h38;
    localparam logic [7:0] ADDR_CPU_MODE = 8'h3b;

    // Processor mode register fields
    localparam int CPUM_SPEED_LSB = 6;
    localparam int CPUM_MAIN_STOP = 5;
    localparam int CPUM_SUB_EN = 4;

    // Miscellaneous clock settings fields
    localparam int MISC_STAB_SEL = 0;
    localparam int MISC_AUTO_EN = 1;
    localparam int MISC_AUTO_WAIT = 2;

    // Status register fields
    localparam int STAT_HALTED = 2;
    localparam int STAT_STABILISING = 3;

    // Sub port register fields
    localparam int PORT_DATA_LSB = 0;
    localparam int PORT_DIR_LSB = 2;
    localparam int PORT_PIN_LSB = 4;

    // Speed codes held in the processor mode register
    localparam logic [1:0] SPEED_HIGH = 2'h0;
    localparam logic [1:0] SPEED_MIDDLE = 2'h1;
    localparam logic [1:0] SPEED_LOW = 2'h2;

    // Reset and load values
    localparam logic [1:0] RESET_SPEED = SPEED_MIDDLE;
    localparam logic [7:0] PRE_STOP_LOAD = 8'hff;
    localparam logic [7:0] TMR_STOP_LOAD = 8'h01;
    localparam logic [3:0] STAB_DIV_LAST = 4'hf;

    // Last tick index of one core clock half period
    localparam logic [1:0] HALF_LAST_MIDDLE = 2'h3;
    localparam logic [1:0] HALF_LAST_OTHER = 2'h0;

    // Low-speed core clock rises counted before the automatic switch
    localparam logic [2:0] AUTO_LAST_SHORT = 3'h4;
    localparam logic [2:0] AUTO_LAST_LONG = 3'h6;

    typedef enum logic [1:0] {
        MODE_HIGH,
        MODE_MIDDLE,
        MODE_LOW
    } scg_mode_type;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_STAB
    } scg_state_type;

endpackage
